// File: hw/etc_top.sv
// external trigger control: mode, trigger sources, completion pulse, axi4-lite registers
`timescale 1ns/1ps

// Operation
// - start in continuous trigger mode after reset
// - config switch on plus resolution key, lockout off: one-shot
// - one-shot triggers only from ratio key or external
// - external falling edge starts one conversion
// - ignore external trigger under inhibit or lockout
// - completion output pulses 400 us per conversion
module etc_top
  import etc_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = etc_pkg::PULSE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // front panel and trigger pins
  input wire logic ext_trig_n,
  input wire logic res_key,
  input wire logic ratio_key,
  input wire logic one_shot_config_switch,
  // converter handshake
  output logic conv_start,
  input wire logic conv_done,
  // completion output
  output logic conv_complete,
  // interrupt
  output logic irq,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [etc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data and response
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [etc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_ff;
  logic [PIN_N-1:0] s2_ff;
  logic [PIN_N-1:0] s3_ff;
  logic [PIN_N-1:0] pin_ff;
  logic [PIN_N-1:0] nxt_pin;
  etc_mode_e mode_ff;
  etc_ctrl_s ctrl_ff;
  etc_irq_s irq_stat_ff;
  etc_irq_s irq_mask_ff;
  etc_irq_s evt;
  logic running_ff;
  logic conv_start_ff;
  logic ext_fall;
  logic res_press;
  logic ratio_press;
  logic ext_allowed;
  logic trig_ok;
  logic to_cont;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic wr_fire;
  logic [2:0] w1c;
  logic [3:0] aw_sel;

  // decode a byte address into a one-hot register select, zero if unmapped
  function automatic logic [3:0] etc_dec(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL: etc_dec = 4'h1;
      OFS_STATUS: etc_dec = 4'h2;
      OFS_IRQ_STAT: etc_dec = 4'h4;
      OFS_IRQ_MASK: etc_dec = 4'h8;
      default: etc_dec = 4'h0;
    endcase
  endfunction

  // one-hot select of the captured write address
  assign aw_sel = etc_dec(awaddr_ff);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  assign pin_raw = {one_shot_config_switch, ratio_key, res_key, ext_trig_n};

  // three stages; a level is accepted only once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++) begin : g_sync
      assign nxt_pin[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : pin_ff[gi];
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          s1_ff[gi] <= PIN_IDLE[gi];
          s2_ff[gi] <= PIN_IDLE[gi];
          s3_ff[gi] <= PIN_IDLE[gi];
          pin_ff[gi] <= PIN_IDLE[gi];
        end else begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          pin_ff[gi] <= nxt_pin[gi];
        end
      end
    end
  endgenerate

  // edges on the filtered levels only, so one pin edge gives one event
  assign ext_fall = pin_ff[PIN_TRIG_N] && !nxt_pin[PIN_TRIG_N];
  assign res_press = !pin_ff[PIN_RES_KEY] && nxt_pin[PIN_RES_KEY];
  assign ratio_press = !pin_ff[PIN_RATIO_KEY] && nxt_pin[PIN_RATIO_KEY];

  // ************************************************************
  // trigger mode
  // ************************************************************
  assign to_cont = wr_fire && aw_sel[0] && wstrb0_ff && wdata_ff[CTRL_TO_CONT];

  // lockout blocks the resolution key, so it cannot change the mode; the ratio key still triggers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_ff <= CONTINUOUS_TRIGGER_MODE;
    end else begin
      case (mode_ff)
        CONTINUOUS_TRIGGER_MODE: begin
          if (res_press && pin_ff[PIN_CFG_SW] && !ctrl_ff.front_panel_lockout) begin
            mode_ff <= ONE_SHOT_TRIGGER_MODE;
          end
        end
        ONE_SHOT_TRIGGER_MODE: begin
          if (to_cont) begin
            mode_ff <= CONTINUOUS_TRIGGER_MODE;
          end
        end
        default: mode_ff <= CONTINUOUS_TRIGGER_MODE;
      endcase
    end
  end

  // ************************************************************
  // conversion start
  // ************************************************************
  assign ext_allowed = ext_fall && !ctrl_ff.trigger_inhibit_setting
                       && !ctrl_ff.front_panel_lockout;
  assign trig_ok = (mode_ff == ONE_SHOT_TRIGGER_MODE) && !running_ff
                   && (ratio_press || ext_allowed);

  // continuous mode restarts as soon as the converter reports done
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      conv_start_ff <= 1'b0;
      running_ff <= 1'b0;
    end else begin
      conv_start_ff <= !conv_start_ff && (trig_ok
                       || (mode_ff == CONTINUOUS_TRIGGER_MODE && !running_ff));
      if (conv_start_ff) begin
        running_ff <= 1'b1;
      end else if (conv_done) begin
        running_ff <= 1'b0;
      end
    end
  end
  assign conv_start = conv_start_ff;

  // ************************************************************
  // completion pulse
  // ************************************************************
  etc_pulse #(
    .CYCLES(PULSE_CYCLES),
    .CW(CNT_W)
  ) u_pulse (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(conv_done),
    .active(conv_complete)
  );

  // ************************************************************
  // interrupts
  // ************************************************************
  assign evt.trig_taken = trig_ok;
  assign evt.conv_done = conv_done;
  assign evt.trig_ignored = ext_fall && !trig_ok;
  assign w1c = (wr_fire && aw_sel[2] && wstrb0_ff) ? wdata_ff[2:0] : 3'h0;

  // a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat_ff <= IRQ_RESET;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~w1c) | evt;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;

  // address and data may come in either order; the response waits for both
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= (aw_sel == 4'h0) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // control and mask registers; status is read-only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET;
      irq_mask_ff <= IRQ_RESET;
    end else if (wr_fire && wstrb0_ff) begin
      if (aw_sel[0]) begin
        ctrl_ff <= wdata_ff[CTRL_LOCKOUT:CTRL_INHIBIT];
      end
      if (aw_sel[3]) begin
        irq_mask_ff <= wdata_ff[2:0];
      end
    end
  end

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  assign s_axi_arready = !rvalid_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= (etc_dec(s_axi_araddr) == 4'h0) ? RESP_SLVERR : RESP_OKAY;
      case (etc_dec(s_axi_araddr))
        4'h1: rdata_ff <= {30'h0, ctrl_ff};
        4'h2: rdata_ff <= {27'h0, pin_ff[PIN_CFG_SW], running_ff, conv_complete,
                           mode_ff == ONE_SHOT_TRIGGER_MODE, 1'b0};
        4'h4: rdata_ff <= {29'h0, irq_stat_ff};
        4'h8: rdata_ff <= {29'h0, irq_mask_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ************************************************************
  // checks
  // ************************************************************
  logic [CNT_W-1:0] hi_cnt_ff;

  // cycles the completion output has been high since the last restart
  always_ff @(posedge ref_clk) begin
    if (reset || conv_done) begin
      hi_cnt_ff <= '0;
    end else if (conv_complete) begin
      hi_cnt_ff <= hi_cnt_ff + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_reset_mode: assert property ($fell(reset) |-> mode_ff == CONTINUOUS_TRIGGER_MODE)
    else $error("mode not continuous after reset");
  chk_enter_oneshot: assert property (res_press && pin_ff[PIN_CFG_SW]
    && !ctrl_ff.front_panel_lockout |=> mode_ff == ONE_SHOT_TRIGGER_MODE)
    else $error("one-shot mode not entered");
  chk_oneshot_source: assert property (mode_ff == ONE_SHOT_TRIGGER_MODE
    && $past(mode_ff) == ONE_SHOT_TRIGGER_MODE && conv_start_ff
    |-> $past(ratio_press || ext_allowed))
    else $error("one-shot start without trigger");
  chk_ext_start: assert property (ext_allowed && mode_ff == ONE_SHOT_TRIGGER_MODE
    && !running_ff && !conv_start_ff |=> conv_start_ff)
    else $error("external edge did not start");
  chk_ext_inhibit: assert property (ext_fall && !ratio_press && mode_ff == ONE_SHOT_TRIGGER_MODE
    && (ctrl_ff.trigger_inhibit_setting || ctrl_ff.front_panel_lockout) |=> !conv_start_ff)
    else $error("inhibited trigger started");
  chk_pulse_rise: assert property (conv_done |=> conv_complete[*8])
    else $error("completion pulse missing");
  chk_pulse_width: assert property ($fell(conv_complete) |-> hi_cnt_ff == CNT_W'(PULSE_CYCLES))
    else $error("completion pulse width wrong");
  chk_single_start: assert property (conv_start_ff |=> !conv_start_ff ##1 running_ff)
    else $error("start not single");

  cov_oneshot: cover property (mode_ff == ONE_SHOT_TRIGGER_MODE ##1 conv_start_ff);
  cov_ignored: cover property (evt.trig_ignored);
  cov_pulse: cover property ($fell(conv_complete));

endmodule

// File: hw/etc_pkg.sv
// package: constants, register map and carrier types of the trigger control block
package etc_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PULSE_US = 400;
  // completion pulse width in ref_clk cycles, rounded down
  localparam int unsigned PULSE_CYCLES = (PULSE_US * (CLK_HZ / 1000)) / 1000;
  localparam int unsigned CNT_W = 16;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ctrl fields
  localparam int unsigned CTRL_INHIBIT = 0;
  localparam int unsigned CTRL_LOCKOUT = 1;
  localparam int unsigned CTRL_TO_CONT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // ************************************************************
  // pin inputs: bit order and idle levels
  // ************************************************************
  localparam int unsigned PIN_N = 4;
  localparam int unsigned PIN_TRIG_N = 0;
  localparam int unsigned PIN_RES_KEY = 1;
  localparam int unsigned PIN_RATIO_KEY = 2;
  localparam int unsigned PIN_CFG_SW = 3;
  localparam logic [3:0] PIN_IDLE = 4'h1;

  // trigger mode, one-hot
  typedef enum logic [1:0] {
    CONTINUOUS_TRIGGER_MODE = 2'b01,
    ONE_SHOT_TRIGGER_MODE = 2'b10
  } etc_mode_e;

  // software control bits
  typedef struct packed {
    logic front_panel_lockout;
    logic trigger_inhibit_setting;
  } etc_ctrl_s;

  // sticky events, same layout in status and mask
  typedef struct packed {
    logic trig_ignored;
    logic conv_done;
    logic trig_taken;
  } etc_irq_s;

endpackage

// File: hw/etc_pulse.sv
// fixed-width pulse generator for the completion output
`timescale 1ns/1ps

module etc_pulse #(
  parameter int unsigned CYCLES = 10000,
  parameter int unsigned CW = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // trigger and pulse
  input wire logic start,
  output logic active
);

  // ************************************************************
  // width counter
  // ************************************************************
  logic [CW-1:0] cnt_ff;

  // a new start restarts the width, so back-to-back ends merge into one pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_ff <= '0;
      active <= 1'b0;
    end else if (start) begin
      cnt_ff <= CW'(CYCLES - 1);
      active <= 1'b1;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end else begin
      active <= 1'b0;
    end
  end

endmodule

// File: verif/etc_scanner.sv
// partner model: scanner that sends triggers and listens to completion
`timescale 1ns/1ps

module etc_scanner #(
  parameter int unsigned LOW_CYC = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bench commands
  input wire logic fire,
  input wire logic auto_adv,
  // instrument lines
  input wire logic conv_complete,
  output logic ext_trig_n
);
  logic cc_ff;
  int cnt_ff;

  // low phase counter, held well past the pin filter span
  always @(posedge ref_clk) begin
    cc_ff <= conv_complete;
    if (reset) begin
      cnt_ff <= 0;
    end else if (fire || (auto_adv && conv_complete && !cc_ff)) begin
      cnt_ff <= LOW_CYC;
    end else if (cnt_ff != 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end

  // pulled-up line: high unless a trigger is being sent
  assign ext_trig_n = (cnt_ff == 0);
endmodule

// File: verif/tb_external_trigger_control.sv
// testbench: trigger control block against a scanner and a converter stand-in
`timescale 1ns/1ps

module tb_external_trigger_control;
  import etc_pkg::*;
  localparam int unsigned PC = 20;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ext_trig_n, res_key, ratio_key, sw, conv_start, conv_done, conv_complete, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, br, rr;
  logic fire, auto_adv;
  int miscompares, n_checks, n_start, s, w, cd, n;
  bit busy;

  // ********************
  // clock and instances
  // ********************
  always #20 ref_clk = ~ref_clk;

  etc_top #(.PULSE_CYCLES(PC)) dut (
    .ref_clk(ref_clk), .reset(reset), .ext_trig_n(ext_trig_n), .res_key(res_key),
    .ratio_key(ratio_key), .one_shot_config_switch(sw), .conv_start(conv_start),
    .conv_done(conv_done), .conv_complete(conv_complete), .irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp));

  etc_scanner scan (.ref_clk(ref_clk), .reset(reset), .fire(fire), .auto_adv(auto_adv),
    .conv_complete(conv_complete), .ext_trig_n(ext_trig_n));

  // ********************
  // tasks
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ends at a falling edge so counters have settled
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // one write; address and data offered together, released as taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge ref_clk);
      if (!ta && awready === 1'b1) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge ref_clk);
    br = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask

  // key held long enough to pass the pin filter
  task automatic press(input bit ratio);
    @(posedge ref_clk);
    if (ratio) ratio_key <= 1'b1;
    else res_key <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ratio_key <= 1'b0;
    res_key <= 1'b0;
    wt(80);
  endtask

  task automatic trig();
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    wt(80);
  endtask

  // ********************
  // monitors and converter stand-in
  // ********************
  // converter: random conversion time, counts every start
  always @(posedge ref_clk) begin
    conv_done <= 1'b0;
    if (busy) begin
      if (cd == 0) begin
        conv_done <= 1'b1;
        busy = 0;
      end else cd--;
    end else if (conv_start === 1'b1) begin
      busy = 1;
      cd = $urandom_range(40, 25);
    end
    if (conv_start === 1'b1) n_start++;
  end

  // completion width checked on every pulse; spacing keeps pulses apart
  always @(posedge ref_clk) begin
    if (conv_complete === 1'b1) w++;
    else if (w != 0) begin
      check(w, PC);
      w = 0;
    end
  end

  // watchdog: the whole sequence needs about 1500 cycles
  initial begin
    wt(20000);
    miscompares++;
    print_verdict();
  end

  // ********************
  // main sequence
  // ********************
  initial begin
    {res_key, ratio_key, sw, fire, auto_adv, conv_done} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    void'($urandom(21));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    wt(60);
    axr(OFS_STATUS);
    check(rd[1], 1'b0);
    check(rr, RESP_OKAY);
    check(n_start > 0, 1'b1);
    axr(4'h2);
    check(rd, 32'h0);
    check(rr, RESP_SLVERR);
    $display("test power_up done");
    @(posedge ref_clk);
    sw <= 1'b1;
    wt(6);
    press(1'b0);
    axr(OFS_STATUS);
    check(rd[1], 1'b1);
    check(rd[4], 1'b1);
    wt(0);
    s = n_start;
    wt(100);
    check(n_start, s);
    $display("test mode_entry done");
    axw(OFS_IRQ_STAT, 32'h7);
    axw(OFS_IRQ_MASK, 32'h1);
    check(br, RESP_OKAY);
    wt(0);
    s = n_start;
    trig();
    check(n_start, s + 1);
    check(irq, 1'b1);
    axr(OFS_IRQ_STAT);
    check(rd[2:0], 3'h3);
    axw(OFS_IRQ_STAT, 32'h7);
    wt(1);
    check(irq, 1'b0);
    $display("test ext_trigger done");
    n = $urandom_range(3, 1);
    s = n_start;
    repeat (n) press(1'b1);
    press(1'b0);
    check(n_start, s + n);
    $display("test keys done");
    // inhibit first, then lockout; masked event keeps irq low
    for (int i = 0; i < 2; i++) begin
      axw(OFS_CTRL, 32'h1 << i);
      axw(OFS_IRQ_STAT, 32'h7);
      wt(0);
      s = n_start;
      trig();
      check(n_start, s);
      check(irq, 1'b0);
      axr(OFS_IRQ_STAT);
      check(rd[2:0], 3'h4);
    end
    axw(OFS_CTRL, 32'h0);
    $display("test blocking done");
    @(posedge ref_clk);
    auto_adv <= 1'b1;
    wt(0);
    s = n_start;
    trig();
    wt(300);
    check(n_start - s > 4, 1'b1);
    @(posedge ref_clk);
    auto_adv <= 1'b0;
    wt(150);
    $display("test scanner_chain done");
    // software return to continuous mode
    axw(OFS_CTRL, 32'h4);
    axr(OFS_STATUS);
    check(rd[1], 1'b0);
    $display("test return_cont done");
    print_verdict();
  end
endmodule
